// >>> common/dbg_watch_pkg.sv
// shared constants and encodings for the watchpoint, counter and trap enable logic
package dbg_watch_pkg;
    // block dimensions
    localparam int CNT_W = 16;
    localparam int IW_N = 4;
    localparam int LW_N = 2;
    localparam int SRC_N = 8;
    localparam int TE_W = 6;
    localparam int FRAME_BITS = 10;
    localparam int BITCNT_W = 4;

    // selection of the instruction watchpoint that qualifies a load/store watchpoint
    localparam logic [2:0] IW_SEL_IGNORE = 3'h4;

    // load/store address event choices
    typedef enum logic [2:0] {
        ADDR_E = 3'b000,
        ADDR_F = 3'b001,
        ADDR_AND = 3'b010,
        ADDR_OR = 3'b011,
        ADDR_IGNORE = 3'b100
    } addr_sel_e;

    // load/store data event choices
    typedef enum logic [2:0] {
        DATA_G = 3'b000,
        DATA_H = 3'b001,
        DATA_AND = 3'b010,
        DATA_OR = 3'b011,
        DATA_IGNORE = 3'b100
    } data_sel_e;

    // counter sources: codes 0..3 are instruction watchpoints
    localparam logic [2:0] CSRC_LW_FIRST = 3'h4;
    localparam logic [2:0] CSRC_LW_SECOND = 3'h5;

    // trap enable layout: software word and port frame share the low six bits
    localparam int TE_ITE_LSB = 0;
    localparam int TE_LTE_LSB = 4;
    localparam int FR_NMI_BP = 6;
    localparam int FR_MASK_BP = 7;
    localparam int FR_VSYNC_LSB = 8;
    localparam logic [1:0] VSYNC_START = 2'h1;
    localparam logic [1:0] VSYNC_STOP = 2'h2;

    // debug entry source positions
    localparam int SRC_INSTR_BP = 0;
    localparam int SRC_LS_BP = 1;
    localparam int SRC_CNT_FIRST = 2;
    localparam int SRC_CNT_SECOND = 3;
    localparam int SRC_PORT_NMI = 4;
    localparam int SRC_PORT_MASK = 5;
    localparam int SRC_PERIPH = 6;
    localparam int SRC_CORE_IRQ = 7;

    // values after reset, and the bit count of a frame's last bit
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [TE_W-1:0] TE_RST = 6'h00;
    localparam logic [FRAME_BITS-1:0] FRAME_RST = 10'h000;
    localparam logic [BITCNT_W-1:0] BITCNT_LAST = 4'h9;
endpackage

// >>> common/dport_if.sv
// carrier for a received trap enable frame between the link and core domains
`timescale 1ns/1ps
interface dport_if;
    logic [9:0] word;
    logic toggle;
    modport link (output word, output toggle);
    modport core (input word, input toggle);
endinterface

// >>> rtl/dport_link.sv
// serial development port receiver/echo running on the tool's clock
`timescale 1ns/1ps
module dport_link
    import dbg_watch_pkg::*;
(
    input wire logic dport_clk,
    input wire logic link_rst,
    input wire logic dport_frame,
    input wire logic dport_din,
    output logic dport_dout,
    dport_if.link lk
);
    logic [FRAME_BITS-1:0] shift_q;
    logic [BITCNT_W-1:0] bitcnt_q;
    logic [FRAME_BITS-1:0] word_q;
    logic toggle_q;
    logic dout_q;
    logic frame_clr;

    // the tool's clock may stop between frames, so the frame itself clears the bit count
    assign frame_clr = link_rst | ~dport_frame;

    // bit counter, lsb first
    always_ff @(posedge dport_clk or posedge frame_clr) begin
        if (frame_clr) begin
            bitcnt_q <= '0;
        end else if (bitcnt_q == BITCNT_LAST) begin
            bitcnt_q <= '0;
        end else begin
            bitcnt_q <= bitcnt_q + 4'h1;
        end
    end

    // shift in and latch a finished frame; toggle marks it for the core side
    always_ff @(posedge dport_clk or posedge link_rst) begin
        if (link_rst) begin
            shift_q <= FRAME_RST;
            word_q <= FRAME_RST;
            toggle_q <= 1'b0;
            dout_q <= 1'b0;
        end else if (dport_frame) begin
            shift_q <= {dport_din, shift_q[FRAME_BITS-1:1]};
            dout_q <= word_q[bitcnt_q]; // echo of last frame, full duplex
            if (bitcnt_q == BITCNT_LAST) begin
                word_q <= {dport_din, shift_q[FRAME_BITS-1:1]};
                toggle_q <= ~toggle_q;
            end
        end
    end

    assign lk.word = word_q;
    assign lk.toggle = toggle_q;
    assign dport_dout = dout_q;
endmodule

// >>> rtl/watch_trap_core.sv
// load/store watchpoints, debug counters, trap enables and debug entry control
// Contract
// - each load/store watchpoint picks an instruction, address and data qualifier
// - with address and data ignored, only load/store instructions fire it
// - two 16-bit down counters, each counting one selected watchpoint
// - a counted event at a count of one raises its breakpoint
// - masked mode: no counting while the recoverable interrupt bit is 0
// - instruction count end: breakpoint before execution, handler sees one
// - load/store count end: instruction completes, handler sees zero
// - effective trap enables are software OR port enables
// - both trap enable sets can be read back
// - port frame carries trap enables, two breakpoints and show-cycle code
// - dedicated serial port, may run slower than the core
// - debug mode enable is chosen only during reset
// - in debug mode instructions come from the port; here the port only carries trap enable frames
// - return from interrupt leaves debug mode
// - each source routes to its vector or to debug entry
// - sources include two port request levels and a peripheral breakpoint
// - masked mode after reset; no-mask bit unmasks all internal breakpoints
// - G is OR of byte lanes; G and H must match on one lane
`timescale 1ns/1ps
module watch_trap_core
    import dbg_watch_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic dport_clk,
    input wire logic dport_frame,
    input wire logic dport_din,
    output logic dport_dout,
    input wire logic debug_strap_pin,
    input wire logic instr_valid,
    input wire logic [dbg_watch_pkg::IW_N-1:0] instr_watch,
    input wire logic ls_valid,
    input wire logic addr_e_match,
    input wire logic addr_f_match,
    input wire logic [3:0] g_match,
    input wire logic [3:0] h_match,
    input wire logic recoverable_irq_state,
    input wire logic problem_state_bit,
    input wire logic breakpoint_nomask,
    input wire logic [dbg_watch_pkg::LW_N-1:0][2:0] lw_iw_sel,
    input wire logic [dbg_watch_pkg::LW_N-1:0][2:0] lw_addr_sel,
    input wire logic [dbg_watch_pkg::LW_N-1:0][2:0] lw_data_sel,
    input wire logic [dbg_watch_pkg::LW_N-1:0][2:0] cnt_src,
    input wire logic [dbg_watch_pkg::LW_N-1:0] cnt_load,
    input wire logic [dbg_watch_pkg::LW_N-1:0][dbg_watch_pkg::CNT_W-1:0] cnt_load_val,
    input wire logic sw_te_wr,
    input wire logic [dbg_watch_pkg::TE_W-1:0] sw_te_data,
    input wire logic periph_bp_int,
    input wire logic periph_bp_ext,
    input wire logic core_irq,
    input wire logic [dbg_watch_pkg::SRC_N-1:0] debug_route,
    input wire logic rfi_retire,
    output logic [dbg_watch_pkg::LW_N-1:0] ls_watch,
    output logic [dbg_watch_pkg::LW_N-1:0][dbg_watch_pkg::CNT_W-1:0] count,
    output logic instr_bp,
    output logic ls_bp,
    output logic [dbg_watch_pkg::LW_N-1:0] cnt_bp,
    output logic [dbg_watch_pkg::SRC_N-1:0] vector_req,
    output logic debug_enabled,
    output logic debug_mode,
    output logic vsync_active,
    output logic [dbg_watch_pkg::TE_W-1:0] sw_te,
    output logic [dbg_watch_pkg::TE_W-1:0] port_te
);
    // address event of one watchpoint
    function automatic logic addr_event(input logic [2:0] sel, input logic e, input logic f);
        unique case (sel)
            ADDR_E: addr_event = e;
            ADDR_F: addr_event = f;
            ADDR_AND: addr_event = e & f;
            ADDR_OR: addr_event = e | f;
            ADDR_IGNORE: addr_event = 1'b1;
            default: addr_event = 1'b0; // unused codes never match
        endcase
    endfunction

    // data event of one watchpoint; the AND form pairs lanes
    function automatic logic data_event(input logic [2:0] sel, input logic [3:0] g,
                                        input logic [3:0] h);
        unique case (sel)
            DATA_G: data_event = |g;
            DATA_H: data_event = |h;
            DATA_AND: data_event = |(g & h);
            DATA_OR: data_event = |(g | h);
            DATA_IGNORE: data_event = 1'b1;
            default: data_event = 1'b0;
        endcase
    endfunction

    // instruction watchpoint chosen by a three-bit code
    function automatic logic iw_pick(input logic [2:0] sel, input logic [IW_N-1:0] iw);
        if (sel == IW_SEL_IGNORE) begin
            iw_pick = 1'b1;
        end else if (sel < IW_SEL_IGNORE) begin
            iw_pick = iw[sel[1:0]];
        end else begin
            iw_pick = 1'b0;
        end
    endfunction

    dport_if u_if ();

    dport_link u_link (
        .dport_clk(dport_clk),
        .link_rst(sys_rst),
        .dport_frame(dport_frame),
        .dport_din(dport_din),
        .dport_dout(dport_dout),
        .lk(u_if.link)
    );

    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic strap_s1_q, strap_s2_q;
    logic [IW_N-1:0] iw_hit;
    logic [LW_N-1:0] lw_d;
    logic [LW_N-1:0] lw_q;
    logic recognize;
    logic [TE_W-1:0] te_eff;
    logic [TE_W-1:0] sw_te_q, port_te_q;
    logic [LW_N-1:0][CNT_W-1:0] cnt_q;
    logic [LW_N-1:0] cnt_bp_q;
    logic instr_bp_q, ls_bp_q;
    logic port_nmi_q, port_mask_q;
    logic vsync_q;
    logic dbg_en_q, dbg_mode_q;
    logic [SRC_N-1:0] src_d;
    logic [SRC_N-1:0] to_debug;
    logic [SRC_N-1:0] vec_q;
    logic frame_new;

    // frame toggle and strap pin each pass two flops before use
    always_ff @(posedge sys_clk) begin
        tog_s1_q <= u_if.toggle;
        tog_s2_q <= tog_s1_q;
        strap_s1_q <= debug_strap_pin;
        strap_s2_q <= strap_s1_q;
    end

    // edge memory for the frame toggle; word is stable long after the toggle moves
    always_ff @(posedge sys_clk) begin
        tog_s3_q <= tog_s2_q;
    end
    assign frame_new = tog_s2_q ^ tog_s3_q;

    // breakpoints only count as recognized when unmasked or recoverable
    assign recognize = breakpoint_nomask | recoverable_irq_state;
    assign te_eff = sw_te_q | port_te_q;
    assign iw_hit = instr_valid ? instr_watch : '0;

    // load/store watchpoint qualification
    always_comb begin
        for (int j = 0; j < LW_N; j++) begin
            lw_d[j] = ls_valid
                & iw_pick(lw_iw_sel[j], iw_hit)
                & addr_event(lw_addr_sel[j], addr_e_match, addr_f_match)
                & data_event(lw_data_sel[j], g_match, h_match);
        end
    end

    // watchpoints are reported whatever the mask state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lw_q <= '0;
        end else begin
            lw_q <= lw_d;
        end
    end

    // software trap enables, refused outside privileged state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sw_te_q <= TE_RST;
        end else if (sw_te_wr && !problem_state_bit) begin
            sw_te_q <= sw_te_data;
        end
    end

    // port frame apply: enables, two breakpoint requests, show-cycle code
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_te_q <= TE_RST;
            port_nmi_q <= 1'b0;
            port_mask_q <= 1'b0;
            vsync_q <= 1'b0;
        end else if (frame_new) begin
            port_te_q <= u_if.word[TE_W-1:0];
            port_nmi_q <= u_if.word[FR_NMI_BP];
            port_mask_q <= u_if.word[FR_MASK_BP];
            if (u_if.word[FR_VSYNC_LSB +: 2] == VSYNC_START) begin
                vsync_q <= 1'b1;
            end else if (u_if.word[FR_VSYNC_LSB +: 2] == VSYNC_STOP) begin
                vsync_q <= 1'b0;
            end
        end else begin
            port_nmi_q <= 1'b0;
            port_mask_q <= 1'b0;
        end
    end

    // breakpoints from watchpoints gated by the combined enables
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            instr_bp_q <= 1'b0;
            ls_bp_q <= 1'b0;
        end else begin
            instr_bp_q <= recognize & |(iw_hit & te_eff[TE_ITE_LSB +: IW_N]);
            ls_bp_q <= recognize & |(lw_d & te_eff[TE_LTE_LSB +: LW_N]);
        end
    end

    // down counters; an instruction source holds at one since that instruction
    // is cancelled, a load/store source lands on zero after it completes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= {LW_N{CNT_RST}};
            cnt_bp_q <= '0;
        end else begin
            for (int i = 0; i < LW_N; i++) begin
                logic ev;
                ev = 1'b0;
                if (cnt_src[i] < CSRC_LW_FIRST) begin
                    ev = iw_hit[cnt_src[i][1:0]];
                end else if (cnt_src[i] == CSRC_LW_FIRST) begin
                    ev = lw_d[0];
                end else if (cnt_src[i] == CSRC_LW_SECOND) begin
                    ev = lw_d[1];
                end
                cnt_bp_q[i] <= 1'b0;
                if (cnt_load[i]) begin
                    cnt_q[i] <= cnt_load_val[i];
                end else if (ev && recognize && cnt_q[i] != CNT_RST) begin
                    if (cnt_q[i] == 16'h0001) begin
                        cnt_bp_q[i] <= 1'b1;
                        if (cnt_src[i] >= CSRC_LW_FIRST) begin
                            cnt_q[i] <= CNT_RST;
                        end
                    end else begin
                        cnt_q[i] <= cnt_q[i] - 16'h0001;
                    end
                end
            end
        end
    end

    // debug mode enable follows the strap only while reset is held
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dbg_en_q <= strap_s2_q;
        end
    end

    // event sources; port maskable and peripheral requests need the recoverable state
    always_comb begin
        src_d = '0;
        src_d[SRC_INSTR_BP] = instr_bp_q;
        src_d[SRC_LS_BP] = ls_bp_q;
        src_d[SRC_CNT_FIRST] = cnt_bp_q[0];
        src_d[SRC_CNT_SECOND] = cnt_bp_q[1];
        src_d[SRC_PORT_NMI] = port_nmi_q;
        src_d[SRC_PORT_MASK] = port_mask_q & recoverable_irq_state;
        src_d[SRC_PERIPH] = (periph_bp_int | periph_bp_ext) & recoverable_irq_state;
        src_d[SRC_CORE_IRQ] = core_irq;
    end
    assign to_debug = src_d & debug_route & {SRC_N{dbg_en_q}};

    // sources not routed to debug go to their normal vector
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vec_q <= '0;
        end else begin
            vec_q <= src_d & ~to_debug;
        end
    end

    // debug mode: entry wins over a return in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dbg_mode_q <= 1'b0;
        end else if (|to_debug) begin
            dbg_mode_q <= 1'b1;
        end else if (dbg_mode_q && rfi_retire) begin
            dbg_mode_q <= 1'b0;
        end
    end

    // outputs, all straight from flops
    assign ls_watch = lw_q;
    assign count = cnt_q;
    assign instr_bp = instr_bp_q;
    assign ls_bp = ls_bp_q;
    assign cnt_bp = cnt_bp_q;
    assign vector_req = vec_q;
    assign debug_enabled = dbg_en_q;
    assign debug_mode = dbg_mode_q;
    assign vsync_active = vsync_q;
    assign sw_te = sw_te_q;
    assign port_te = port_te_q;
endmodule

// >>> sim/watch_trap_core_assertions.sv
// concurrent checks on the watchpoint, counter and trap enable core ports
`timescale 1ns/1ps
module watch_trap_core_checker
    import dbg_watch_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [3:0] instr_watch,
    input wire logic ls_valid,
    input wire logic [3:0] g_match,
    input wire logic [3:0] h_match,
    input wire logic recoverable_irq_state,
    input wire logic problem_state_bit,
    input wire logic breakpoint_nomask,
    input wire logic [1:0][2:0] lw_iw_sel,
    input wire logic [1:0][2:0] lw_addr_sel,
    input wire logic [1:0][2:0] lw_data_sel,
    input wire logic [1:0][2:0] cnt_src,
    input wire logic [1:0] cnt_load,
    input wire logic sw_te_wr,
    input wire logic [5:0] sw_te_data,
    input wire logic [1:0] ls_watch,
    input wire logic [1:0][15:0] count,
    input wire logic instr_bp,
    input wire logic [1:0] cnt_bp,
    input wire logic debug_enabled,
    input wire logic [5:0] sw_te,
    input wire logic [5:0] port_te
);
    logic iw_hit;
    // link side is only seen through port_te, so one domain is enough
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // first counter sees an instruction watchpoint event, no load competing
    assign iw_hit = instr_valid && cnt_src[0] < 3'h4 && instr_watch[cnt_src[0][1:0]]
        && !cnt_load[0];
    property p_ls_only;
        !ls_valid |=> ls_watch == 2'h0;
    endproperty
    a_ls_only: assert property (p_ls_only) else $error("watch fired off load/store");
    property p_and_lane;
        ls_valid && instr_valid && lw_iw_sel[0] == IW_SEL_IGNORE && lw_addr_sel[0] == ADDR_IGNORE
            && lw_data_sel[0] == DATA_AND |=> ls_watch[0] == $past(|(g_match & h_match));
    endproperty
    a_and_lane: assert property (p_and_lane) else $error("same lane data event wrong");
    property p_masked;
        !recoverable_irq_state && !breakpoint_nomask && !cnt_load[0]
            |=> count[0] == $past(count[0]);
    endproperty
    a_masked: assert property (p_masked) else $error("counted while masked");
    property p_dec_one;
        iw_hit && recoverable_irq_state && count[0] > 16'h0001
            |=> count[0] == $past(count[0]) - 16'h0001;
    endproperty
    a_dec_one: assert property (p_dec_one) else $error("counter step wrong");
    property p_iw_end;
        iw_hit && recoverable_irq_state && count[0] == 16'h0001
            |=> cnt_bp[0] && count[0] == 16'h0001;
    endproperty
    a_iw_end: assert property (p_iw_end) else $error("instruction count end wrong");
    property p_trap_or;
        1'b1 |=> instr_bp == $past(instr_valid && |(instr_watch & (sw_te[3:0] | port_te[3:0]))
            && (recoverable_irq_state || breakpoint_nomask));
    endproperty
    a_trap_or: assert property (p_trap_or) else $error("instruction breakpoint wrong");
    property p_sw_guard;
        sw_te_wr |=> sw_te == ($past(problem_state_bit) ? $past(sw_te) : $past(sw_te_data));
    endproperty
    a_sw_guard: assert property (p_sw_guard) else $error("trap enable write wrong");
    property p_strap;
        1'b1 |=> $stable(debug_enabled);
    endproperty
    a_strap: assert property (p_strap) else $error("debug enable changed");
endmodule
bind watch_trap_core watch_trap_core_checker i_chk (
    .sys_clk, .sys_rst, .instr_valid, .instr_watch, .ls_valid, .g_match, .h_match,
    .recoverable_irq_state, .problem_state_bit, .breakpoint_nomask, .lw_iw_sel, .lw_addr_sel,
    .lw_data_sel, .cnt_src, .cnt_load, .sw_te_wr, .sw_te_data, .ls_watch, .count, .instr_bp,
    .cnt_bp, .debug_enabled, .sw_te, .port_te
);

// >>> sim/dport_tool.sv
// external debug tool model shifting trap enable frames
`timescale 1ns/1ps
module dport_tool (
    output logic dport_clk,
    output logic dport_frame,
    output logic dport_din,
    input wire logic dport_dout
);
    initial begin
        dport_clk = 1'b0;
        dport_frame = 1'b0;
        dport_din = 1'b0;
    end
    // clock runs only inside a frame; fewer than ten bits abandons it
    // echo is taken on the falling edge, after the rising edge has launched it
    task automatic send(input logic [9:0] w, input int nbits, output logic [9:0] echo);
        echo = 10'h000;
        for (int i = 0; i < nbits; i++) begin
            dport_frame = 1'b1;
            dport_din = w[i];
            #7.5 dport_clk = 1'b1;
            #7.5 dport_clk = 1'b0;
            echo[i] = dport_dout;
        end
        dport_frame = 1'b0;
        dport_din = ~dport_din; // stale level must not look valid
    endtask
endmodule

// >>> sim/watch_trap_core_tb.sv
// self-checking bench for the watchpoint, counter and trap enable core
`timescale 1ns/1ps
module watch_trap_core_tb;
    import dbg_watch_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, debug_strap_pin = 1'b1, instr_valid = 1'b0;
    logic ls_valid = 1'b0, addr_e_match = 1'b0, addr_f_match = 1'b0, core_irq = 1'b0;
    logic recoverable_irq_state = 1'b1, problem_state_bit = 1'b0, breakpoint_nomask = 1'b0;
    logic sw_te_wr = 1'b0, periph_bp_int = 1'b0, periph_bp_ext = 1'b0, rfi_retire = 1'b0;
    logic [3:0] instr_watch = 4'h0, g_match = 4'h0, h_match = 4'h0;
    logic [1:0][2:0] lw_iw_sel = 6'h24, lw_addr_sel = 6'h24, lw_data_sel = 6'h24, cnt_src = 6'h36;
    logic [1:0] cnt_load = 2'h0;
    logic [1:0][15:0] cnt_load_val = 32'h0;
    logic [5:0] sw_te_data = 6'h00;
    logic [7:0] debug_route = 8'h00;
    logic dport_clk, dport_frame, dport_din, dport_dout, instr_bp, ls_bp, debug_enabled;
    logic debug_mode, vsync_active;
    logic [1:0] ls_watch, cnt_bp;
    logic [1:0][15:0] count;
    logic [7:0] vector_req;
    logic [5:0] sw_te, port_te;
    logic [9:0] last_w = 10'h000;
    int miscompares = 0, num_checks = 0, seed = 32'hE51A;

    watch_trap_core i_dut (.sys_clk, .sys_rst, .dport_clk, .dport_frame, .dport_din, .dport_dout,
        .debug_strap_pin, .instr_valid, .instr_watch, .ls_valid, .addr_e_match, .addr_f_match,
        .g_match, .h_match, .recoverable_irq_state, .problem_state_bit, .breakpoint_nomask,
        .lw_iw_sel, .lw_addr_sel, .lw_data_sel, .cnt_src, .cnt_load, .cnt_load_val, .sw_te_wr,
        .sw_te_data, .periph_bp_int, .periph_bp_ext, .core_irq, .debug_route, .rfi_retire,
        .ls_watch, .count, .instr_bp, .ls_bp, .cnt_bp, .vector_req, .debug_enabled,
        .debug_mode, .vsync_active, .sw_te, .port_te);
    dport_tool i_tool (.dport_clk, .dport_frame, .dport_din, .dport_dout);

    always #10 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // reference watchpoint from the present qualifier settings
    function automatic logic lw_model(int k);
        logic i, a, d;
        i = lw_iw_sel[k] < 3'h4 ? instr_watch[lw_iw_sel[k][1:0]] : lw_iw_sel[k] == 3'h4;
        case (lw_addr_sel[k])
            ADDR_E: a = addr_e_match;
            ADDR_F: a = addr_f_match;
            ADDR_AND: a = addr_e_match & addr_f_match;
            ADDR_OR: a = addr_e_match | addr_f_match;
            ADDR_IGNORE: a = 1'b1;
            default: a = 1'b0;
        endcase
        case (lw_data_sel[k])
            DATA_G: d = |g_match;
            DATA_H: d = |h_match;
            DATA_AND: d = |(g_match & h_match);
            DATA_OR: d = |(g_match | h_match);
            DATA_IGNORE: d = 1'b1;
            default: d = 1'b0;
        endcase
        return ls_valid && i && a && d;
    endfunction

    // load a counter, then single events; pulses gathered over four cycles
    task automatic cnt_run(input int ch, input logic [2:0] src, input int n, input logic nm);
        int exp_cnt;
        logic bp, ri;
        exp_cnt = n;
        @(posedge sys_clk);
        cnt_src[ch] <= src;
        cnt_load[ch] <= 1'b1;
        cnt_load_val[ch] <= n[15:0];
        breakpoint_nomask <= nm;
        @(posedge sys_clk);
        cnt_load[ch] <= 1'b0;
        repeat (8) begin
            ri = $random(seed);
            @(posedge sys_clk);
            recoverable_irq_state <= ri;
            instr_valid <= 1'b1;
            ls_valid <= src[2];
            instr_watch <= 4'h1 << src[1:0];
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            ls_valid <= 1'b0;
            bp = 1'b0;
            repeat (4) begin
                @(negedge sys_clk);
                bp |= cnt_bp[ch];
            end
            check("cnt_bp", (ri || nm) && exp_cnt == 1, bp);
            if ((ri || nm) && exp_cnt > 0) begin
                exp_cnt = (exp_cnt == 1 && src < 3'h4) ? 1 : exp_cnt - 1;
            end
            check("count", exp_cnt, count[ch]);
        end
    endtask

    task automatic sw_write(input logic [5:0] d, input logic ps);
        @(posedge sys_clk);
        sw_te_wr <= 1'b1;
        sw_te_data <= d;
        problem_state_bit <= ps;
        recoverable_irq_state <= 1'b1;
        breakpoint_nomask <= 1'b0;
        @(posedge sys_clk);
        sw_te_wr <= 1'b0;
        @(negedge sys_clk);
    endtask

    // frames are spaced by the eight-cycle gathering window; echo is the last whole word
    task automatic frame(input logic [9:0] w, input int nbits, input logic [5:0] te,
                         input logic vs);
        logic [7:0] seen;
        logic [9:0] echo, mask;
        seen = 8'h00;
        mask = 10'h3FF >> (10 - nbits);
        i_tool.send(w, nbits, echo);
        check("echo", last_w & mask, echo & mask);
        if (nbits == 10) begin
            last_w = w;
        end
        repeat (8) begin
            @(negedge sys_clk);
            seen |= vector_req;
        end
        check("port_te", te, port_te);
        check("vsync", vs, vsync_active);
        check("port nmi", w[6] && nbits == 10, seen[SRC_PORT_NMI]);
        check("port mask", w[7] && nbits == 10, seen[SRC_PORT_MASK]);
    endtask

    // a load/store rides along with the first instruction watchpoint only
    task automatic pulse(input logic [3:0] iw, input logic pb, output logic [1:0] ib,
                         output logic [7:0] vr);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        ls_valid <= iw[0];
        instr_watch <= iw;
        periph_bp_ext <= pb;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        ls_valid <= 1'b0;
        periph_bp_ext <= 1'b0;
        ib = 2'h0;
        vr = 8'h00;
        repeat (4) begin
            @(negedge sys_clk);
            ib |= {ls_bp, instr_bp};
            vr |= vector_req;
        end
    endtask

    initial begin
        logic [31:0] r;
        logic [1:0] ib;
        logic [7:0] vr;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        debug_strap_pin <= 1'b0;
        @(negedge sys_clk);
        check("count", 32'h0, count);
        check("te", 12'h000, {sw_te, port_te});
        check("debug_enabled", 1'b1, debug_enabled);
        check("debug_mode", 1'b0, debug_mode);
        for (int i = 0; i < 150; i++) begin
            r = $random(seed);
            @(posedge sys_clk);
            instr_valid <= 1'b1;
            ls_valid <= r[0];
            addr_e_match <= r[1];
            addr_f_match <= r[2];
            g_match <= r[6:3];
            h_match <= r[10:7];
            instr_watch <= r[14:11];
            recoverable_irq_state <= r[15];
            lw_iw_sel <= {r[18:16] % 3'h5, i[0] ? 3'h4 : r[21:19] % 3'h5};
            lw_addr_sel <= {r[24:22] % 3'h5, r[27:25] % 3'h5};
            lw_data_sel <= {r[30:28] % 3'h5, r[31:29] % 3'h5};
            @(posedge sys_clk);
            @(negedge sys_clk);
            check("ls_watch", {lw_model(1), lw_model(0)}, ls_watch);
        end
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        ls_valid <= 1'b0;
        lw_iw_sel <= 6'h24;
        lw_addr_sel <= 6'h24;
        lw_data_sel <= 6'h24;
        cnt_run(0, 3'h2, 3, 1'b0);
        cnt_run(1, CSRC_LW_SECOND, 3, 1'b0);
        cnt_run(0, 3'h0, 2, 1'b1);
        sw_write(6'h21, 1'b1);
        check("sw_te", 6'h00, sw_te);
        sw_write(6'h01, 1'b0);
        check("sw_te", 6'h01, sw_te);
        frame(10'h1C2, 10, 6'h02, 1'b1);
        frame(10'h2FF, 5, 6'h02, 1'b1);
        frame(10'h212, 10, 6'h12, 1'b0);
        for (int k = 0; k < 3; k++) begin
            pulse(4'h1 << k, 1'b0, ib, vr);
            check("instr_bp", k < 2, ib[0]);
            check("ls_bp", k == 0, ib[1]);
            check("vector", k < 2, vr[SRC_INSTR_BP]);
        end
        @(posedge sys_clk);
        debug_route <= 8'h41;
        pulse(4'h1, 1'b0, ib, vr);
        check("debug_mode", 1'b1, debug_mode);
        check("vector", 1'b0, vr[SRC_INSTR_BP]);
        @(posedge sys_clk);
        rfi_retire <= 1'b1;
        @(posedge sys_clk);
        rfi_retire <= 1'b0;
        @(negedge sys_clk);
        check("debug_mode", 1'b0, debug_mode);
        pulse(4'h0, 1'b1, ib, vr);
        check("debug_mode", 1'b1, debug_mode);
        finish_test();
    end
endmodule
